// ==== logic/dac_word_pkg.sv ====
// Purpose: shared constants and types for the dual converter word decoder
// Assumes: 16-bit command words, 12-bit payload, MSB first
// Notes:   select and reference encodings are fixed by the word format
package dac_word_pkg;

    localparam int WORD_BITS    = 16;
    localparam int PAYLOAD_BITS = 12;
    localparam int COUNT_BITS   = 5;
    localparam int REF_BITS     = 2;

    localparam logic [COUNT_BITS-1:0] COUNT_ZERO  = 5'h00;
    localparam logic [COUNT_BITS-1:0] COUNT_FIRST = 5'h01;
    localparam logic [COUNT_BITS-1:0] COUNT_FULL  = 5'h10;

    localparam logic [PAYLOAD_BITS-1:0] CODE_RESET = 12'h000;
    localparam logic [WORD_BITS-1:0]    WORD_RESET = 16'h0000;

    // channel indices for the per-channel latches
    localparam int CHAN_A     = 0;
    localparam int CHAN_B     = 1;
    localparam int CHAN_COUNT = 2;

    typedef struct packed {
        logic                    target_select_high;
        logic                    speed_select_bit;
        logic                    power_down_bit;
        logic                    target_select_low;
        logic [PAYLOAD_BITS-1:0] payload;
    } command_word_t;

    typedef enum logic [1:0] {
        SEL_B_AND_STAGING  = 2'h0,
        SEL_STAGING_ONLY   = 2'h1,
        SEL_A_AND_TRANSFER = 2'h2,
        SEL_REFERENCE      = 2'h3
    } target_sel_t;

    typedef enum logic [REF_BITS-1:0] {
        REF_EXTERNAL_LOW  = 2'h0,
        REF_INTERNAL_1V0  = 2'h1,
        REF_INTERNAL_2V0  = 2'h2,
        REF_EXTERNAL_HIGH = 2'h3
    } reference_code_t;

    typedef struct packed {
        logic            fast_mode;
        logic            power_down;
        reference_code_t reference_code;
    } analog_setting_t;

    localparam analog_setting_t SETTING_RESET = '{
        fast_mode:      1'b0,
        power_down:     1'b0,
        reference_code: REF_EXTERNAL_LOW
    };

endpackage : dac_word_pkg

// ==== logic/sync_two_flop.sv ====
// Purpose: two-flop level synchroniser into the clk_i domain
// Assumes: each bit is an independent level or a toggle
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module sync_two_flop
#(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] level_i,
    output logic      [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] stage_one_reg;
    logic [WIDTH-1:0] stage_two_reg;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            stage_one_reg <= RESET_VALUE;
            stage_two_reg <= RESET_VALUE;
        end
        else
        begin
            stage_one_reg <= level_i;
            stage_two_reg <= stage_one_reg;
        end
    end

    assign level_o = stage_two_reg;

endmodule : sync_two_flop

// ==== logic/link_shifter.sv ====
// Purpose: serial word shifter running on the host serial clock
// Assumes: sclk may stop outside frames; data is stable at falling edges
// Notes:   a full word is published by a toggle on the next rising edge
`timescale 1ns/1ps
module link_shifter
    import dac_word_pkg::*;
(
    input  wire logic                  sclk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  cs_n_i,
    input  wire logic                  sdata_i,
    output logic                       word_toggle_o,
    output logic                       frame_toggle_o,
    output logic                       word_ready_o,
    output logic      [COUNT_BITS-1:0] bit_count_o,
    output logic      [WORD_BITS-1:0]  shift_o,
    output command_word_t              hold_o
);

    logic                  in_frame_reg;
    logic [COUNT_BITS-1:0] count_reg;
    logic [COUNT_BITS-1:0] count_next;
    logic [WORD_BITS-1:0]  shift_reg;
    logic                  ready_reg;
    logic                  published_reg;
    logic                  toggle_reg;
    logic                  frame_tog_reg;
    command_word_t         hold_reg;

    // a 17th bit in the same frame starts a new word
    assign count_next = (!in_frame_reg || count_reg == COUNT_FULL)
                        ? COUNT_FIRST : count_reg + COUNT_FIRST;

    // cleared the moment chip select goes high
    always_ff @(negedge sclk_i or posedge cs_n_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            in_frame_reg <= 1'b0;
        else if (cs_n_i)
            in_frame_reg <= 1'b0;
        else
            in_frame_reg <= 1'b1;
    end

    always_ff @(negedge sclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count_reg     <= COUNT_ZERO;
            shift_reg     <= WORD_RESET;
            frame_tog_reg <= 1'b0;
        end
        else if (!cs_n_i)
        begin
            count_reg <= count_next;
            if (!in_frame_reg)
            begin
                shift_reg     <= {{(WORD_BITS-1){1'b0}}, sdata_i};
                frame_tog_reg <= ~frame_tog_reg;
            end
            else
                shift_reg <= {shift_reg[WORD_BITS-2:0], sdata_i};
        end
    end

    always_ff @(negedge sclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            ready_reg <= 1'b0;
        else
            ready_reg <= !cs_n_i && (count_next == COUNT_FULL);
    end

    // publish on the rising edge after the last bit was sampled
    always_ff @(posedge sclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            toggle_reg <= 1'b0;
            hold_reg   <= WORD_RESET;
        end
        else if (ready_reg && !cs_n_i)
        begin
            toggle_reg <= ~toggle_reg;
            hold_reg   <= shift_reg;
        end
    end

    // ready stays high after the frame, so the clk_i side must know
    // whether the toggle already carried the word; else it commits twice
    always_ff @(posedge sclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            published_reg <= 1'b0;
        else if (ready_reg && !cs_n_i)
            published_reg <= 1'b1;
        else if (!ready_reg)
            published_reg <= 1'b0;
    end

    assign word_toggle_o  = toggle_reg;
    assign frame_toggle_o = frame_tog_reg;
    assign word_ready_o   = ready_reg && !published_reg;
    assign bit_count_o    = count_reg;
    assign shift_o        = shift_reg;
    assign hold_o         = hold_reg;

endmodule : link_shifter

// ==== logic/dual_dac_serial_word_decoder.sv ====
// Purpose: decode serial command words into converter latches and settings
// Assumes: clk_i at 50 MHz, sclk_i from the host, stopped outside frames
// Notes:   latches live in the clk_i domain; full words cross by toggle, short frames on chip select rise
`timescale 1ns/1ps

// Notes on behaviour
// - words are 16 bits: 4 program, 12 payload
// - bit 14 selects fast or slow settling
// - bit 13 set forces power-down
// - select 00 loads channel B and staging
// - select 01 loads staging only
// - select 10 loads A, staging into B
// - select 11 targets the reference latch
// - payload is unsigned code, bit 11 MSB
// - reference word uses only payload bits 1:0
// - 00/11 external, 01 low, 10 high internal
// - single update on rising edge after D0
// - select 10 updates both channels together
// - reference latch survives later channel writes
// - chip select low starts frame, MSB first
// - sixteen bits or chip select rise commits
// - power-on reset clears every latch to zero
module dual_dac_serial_word_decoder
    import dac_word_pkg::*;
(
    input  wire logic                    clk_i,
    input  wire logic                    reset_n_i,
    input  wire logic                    sclk_i,
    input  wire logic                    cs_n_i,
    input  wire logic                    sdata_i,
    output logic      [PAYLOAD_BITS-1:0] channel_a_code_o,
    output logic      [PAYLOAD_BITS-1:0] channel_b_code_o,
    output logic      [PAYLOAD_BITS-1:0] staging_code_o,
    output analog_setting_t              setting_o,
    output logic                         reference_external_o,
    output logic                         reference_high_o,
    output target_sel_t                  last_target_o,
    output logic                         last_partial_o,
    output logic                         word_taken_o
);

    typedef enum {
        FRAME_IDLE,
        FRAME_OPEN
    } frame_state_t;

    // link side
    logic                  link_word_tog;
    logic                  link_frame_tog;
    logic                  link_ready;
    logic [COUNT_BITS-1:0] link_count;
    logic [WORD_BITS-1:0]  link_shift;
    command_word_t         link_hold;

    // crossing
    logic [1:0]            sync_out;
    logic                  word_tog_sync;
    logic                  cs_n_sync;
    logic                  word_tog_seen_reg;
    logic                  frame_done_reg;

    // frame tracking
    frame_state_t          frame_reg;
    frame_state_t          frame_next;

    // commit path
    logic                  full_event;
    logic                  cs_rise;
    logic                  partial_event;
    logic                  commit;
    command_word_t         commit_word;
    target_sel_t           commit_target;

    // latches
    logic [PAYLOAD_BITS-1:0] channel_latch_reg [CHAN_COUNT];
    logic [PAYLOAD_BITS-1:0] staging_value_latch_reg;
    reference_code_t         reference_select_latch_reg;
    logic                    fast_mode_reg;
    logic                    power_down_reg;
    logic [CHAN_COUNT-1:0]   chan_load;
    logic [PAYLOAD_BITS-1:0] chan_source [CHAN_COUNT];
    target_sel_t             last_target_reg;
    logic                    last_partial_reg;
    logic                    word_taken_reg;

    link_shifter u_link
    (
        .sclk_i         (sclk_i),
        .reset_n_i      (reset_n_i),
        .cs_n_i         (cs_n_i),
        .sdata_i        (sdata_i),
        .word_toggle_o  (link_word_tog),
        .frame_toggle_o (link_frame_tog),
        .word_ready_o   (link_ready),
        .bit_count_o    (link_count),
        .shift_o        (link_shift),
        .hold_o         (link_hold)
    );

    // bit 1: chip select (idles high), bit 0: word toggle
    sync_two_flop
    #(
        .WIDTH       (2),
        .RESET_VALUE (2'h2)
    )
    u_sync
    (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .level_i   ({cs_n_i, link_word_tog}),
        .level_o   (sync_out)
    );

    assign cs_n_sync     = sync_out[1];
    assign word_tog_sync = sync_out[0];

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            word_tog_seen_reg <= 1'b0;
        else
            word_tog_seen_reg <= word_tog_sync;
    end

    assign full_event = word_tog_sync ^ word_tog_seen_reg;

    // frame state follows the synchronised chip select
    always_comb
    begin
        frame_next = frame_reg;
        case (frame_reg)
            FRAME_IDLE:
                if (!cs_n_sync)
                    frame_next = FRAME_OPEN;
            FRAME_OPEN:
                if (cs_n_sync)
                    frame_next = FRAME_IDLE;
            default:
                frame_next = FRAME_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            frame_reg <= FRAME_IDLE;
        else
            frame_reg <= frame_next;
    end

    assign cs_rise = (frame_reg == FRAME_OPEN) && cs_n_sync;

    // link count, shift and frame toggle are quiet once chip select is
    // high, so reading them two clocks after the rise is safe; a word
    // already published by toggle is not taken twice
    assign partial_event = cs_rise && !full_event
                           && (link_frame_tog != frame_done_reg)
                           && (link_count != COUNT_ZERO)
                           && ((link_count != COUNT_FULL)
                               || link_ready);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            frame_done_reg <= 1'b0;
        else if (cs_rise)
            frame_done_reg <= link_frame_tog;
    end

    assign commit      = full_event || partial_event;
    assign commit_word = full_event ? link_hold
                                    : command_word_t'(link_shift);
    assign commit_target = target_sel_t'({commit_word.target_select_high,
                                          commit_word.target_select_low});

    // per-channel load decode; B may take payload or staging content
    always_comb
    begin
        chan_load           = '0;
        chan_source[CHAN_A] = commit_word.payload;
        chan_source[CHAN_B] = commit_word.payload;
        if (commit)
        begin
            case (commit_target)
                SEL_B_AND_STAGING:
                    chan_load[CHAN_B] = 1'b1;
                SEL_STAGING_ONLY:
                    chan_load = '0;
                SEL_A_AND_TRANSFER:
                begin
                    chan_load[CHAN_A]   = 1'b1;
                    chan_load[CHAN_B]   = 1'b1;
                    chan_source[CHAN_B] = staging_value_latch_reg;
                end
                SEL_REFERENCE:
                    chan_load = '0;
                default:
                    chan_load = '0;
            endcase
        end
    end

    // both channels load on the same clock edge, so a select 10 word
    // moves the two outputs together
    for (genvar ch = 0; ch < CHAN_COUNT; ch++)
    begin : g_chan
        always_ff @(posedge clk_i or negedge reset_n_i)
        begin
            if (!reset_n_i)
                channel_latch_reg[ch] <= CODE_RESET;
            else if (chan_load[ch])
                channel_latch_reg[ch] <= chan_source[ch];
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            staging_value_latch_reg <= CODE_RESET;
        else if (commit && (commit_target == SEL_B_AND_STAGING
                            || commit_target == SEL_STAGING_ONLY))
            staging_value_latch_reg <= commit_word.payload;
    end

    // only a select 11 word touches the reference latch
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            reference_select_latch_reg <= REF_EXTERNAL_LOW;
        else if (commit && commit_target == SEL_REFERENCE)
            reference_select_latch_reg <= reference_code_t'(
                commit_word.payload[REF_BITS-1:0]);
    end

    // speed and power bits follow every committed word
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            fast_mode_reg  <= 1'b0;
            power_down_reg <= 1'b0;
        end
        else if (commit)
        begin
            fast_mode_reg  <= commit_word.speed_select_bit;
            power_down_reg <= commit_word.power_down_bit;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            last_target_reg  <= SEL_B_AND_STAGING;
            last_partial_reg <= 1'b0;
        end
        else if (commit)
        begin
            last_target_reg  <= commit_target;
            last_partial_reg <= partial_event;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            word_taken_reg <= 1'b0;
        else
            word_taken_reg <= commit;
    end

    assign channel_a_code_o          = channel_latch_reg[CHAN_A];
    assign channel_b_code_o          = channel_latch_reg[CHAN_B];
    assign staging_code_o            = staging_value_latch_reg;
    assign setting_o.fast_mode       = fast_mode_reg;
    // power-down overrides the rest in the analog section
    assign setting_o.power_down      = power_down_reg;
    assign setting_o.reference_code  = reference_select_latch_reg;

    // both external codes decode alike; only 10 picks the high level
    assign reference_external_o =
        (reference_select_latch_reg == REF_EXTERNAL_LOW)
        || (reference_select_latch_reg == REF_EXTERNAL_HIGH);
    assign reference_high_o =
        (reference_select_latch_reg == REF_INTERNAL_2V0);

    assign last_target_o  = last_target_reg;
    assign last_partial_o = last_partial_reg;
    assign word_taken_o   = word_taken_reg;

endmodule : dual_dac_serial_word_decoder

// ==== tb/host_link_model.sv ====
// Purpose: host serial port model driving the converter link
// Assumes: link clock idles high and runs only inside frames
// Notes:   a released data line shows the inverse of its last bit
`timescale 1ns/1ps
module host_link_model
(
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdata_o
);
    initial
    begin
        sclk_o  = 1'b1;
        cs_n_o  = 1'b1;
        sdata_o = 1'b0;
    end

    // low n bits of bits go out, most significant first
    task automatic send(input logic [31:0] bits, input int n);
        #13.7;
        cs_n_o = 1'b0; // frame opens on falling select
        #20;
        for (int i = n - 1; i >= 0; i--)
        begin
            sdata_o = bits[i];
            #20;
            sclk_o = 1'b0;
            #40;
            sclk_o = 1'b1;
            #20;
        end
        cs_n_o  = 1'b1; // all n bits share one select window
        sdata_o = ~sdata_o;
    endtask : send
endmodule : host_link_model

// ==== tb/word_decoder_monitor.sv ====
// Purpose: concurrent checks on the decoder's top-level ports
// Assumes: all outputs live in the clk_i domain
// Notes:   latch moves are tied to the pulse that rises on the same edge
`timescale 1ns/1ps
module word_decoder_monitor
    import dac_word_pkg::*;
(
    input wire logic                    clk_i,
    input wire logic                    reset_n_i,
    input wire logic                    sclk_i,
    input wire logic                    cs_n_i,
    input wire logic                    sdata_i,
    input wire logic [PAYLOAD_BITS-1:0] channel_a_code_o,
    input wire logic [PAYLOAD_BITS-1:0] channel_b_code_o,
    input wire logic [PAYLOAD_BITS-1:0] staging_code_o,
    input wire analog_setting_t         setting_o,
    input wire logic                    reference_external_o,
    input wire logic                    reference_high_o,
    input wire target_sel_t             last_target_o,
    input wire logic                    last_partial_o,
    input wire logic                    word_taken_o
);
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    chk_reset_clear: assert property ($rose(reset_n_i) |->
        channel_a_code_o == CODE_RESET && channel_b_code_o == CODE_RESET
        && staging_code_o == CODE_RESET && setting_o == SETTING_RESET)
        else $error("latches not clear after reset");
    chk_taken_pulse: assert property (word_taken_o |=> !word_taken_o)
        else $error("commit pulse longer than one cycle");
    chk_a_change: assert property ($changed(channel_a_code_o) |->
        word_taken_o && last_target_o == SEL_A_AND_TRANSFER)
        else $error("channel A moved without its select code");
    chk_b_change: assert property ($changed(channel_b_code_o) |->
        word_taken_o && last_target_o inside
        {SEL_B_AND_STAGING, SEL_A_AND_TRANSFER})
        else $error("channel B moved without its select code");
    chk_stage_change: assert property ($changed(staging_code_o) |->
        word_taken_o && last_target_o inside
        {SEL_B_AND_STAGING, SEL_STAGING_ONLY})
        else $error("staging moved without its select code");
    chk_ref_change: assert property
        ($changed(setting_o.reference_code) |->
        word_taken_o && last_target_o == SEL_REFERENCE)
        else $error("reference code moved on a channel word");
    chk_setting_word: assert property ($changed(setting_o) |->
        word_taken_o)
        else $error("settings moved outside a commit");
    chk_b_mirror: assert property (word_taken_o &&
        last_target_o inside {SEL_B_AND_STAGING, SEL_A_AND_TRANSFER}
        |-> channel_b_code_o == staging_code_o)
        else $error("channel B differs from staging after load");
    chk_ref_decode: assert property (reference_external_o ==
        (setting_o.reference_code inside
        {REF_EXTERNAL_LOW, REF_EXTERNAL_HIGH}) && reference_high_o ==
        (setting_o.reference_code == REF_INTERNAL_2V0))
        else $error("reference decode wrong");

    cov_transfer: cover property (word_taken_o &&
        last_target_o == SEL_A_AND_TRANSFER);
    cov_reference: cover property (word_taken_o &&
        last_target_o == SEL_REFERENCE);
    cov_partial: cover property (word_taken_o && last_partial_o);
endmodule : word_decoder_monitor

bind dual_dac_serial_word_decoder word_decoder_monitor mon_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i),
    .cs_n_i(cs_n_i), .sdata_i(sdata_i),
    .channel_a_code_o(channel_a_code_o),
    .channel_b_code_o(channel_b_code_o),
    .staging_code_o(staging_code_o), .setting_o(setting_o),
    .reference_external_o(reference_external_o),
    .reference_high_o(reference_high_o),
    .last_target_o(last_target_o), .last_partial_o(last_partial_o),
    .word_taken_o(word_taken_o));

// ==== tb/dual_dac_serial_word_decoder_tb.sv ====
// Purpose: self-checking bench for the serial word decoder
// Assumes: host model drives the link; clk_i runs at 50 MHz
// Notes:   expectations come from a bench model of the latches
`timescale 1ns/1ps
module dual_dac_serial_word_decoder_tb
    import dac_word_pkg::*;
();
    logic            clk_i;
    logic            reset_n_i;
    wire logic       sclk;
    wire logic       cs_n;
    wire logic       sdata;
    logic [11:0]     a_o;
    logic [11:0]     b_o;
    logic [11:0]     s_o;
    analog_setting_t set_o;
    logic            ext_o;
    logic            high_o;
    logic            part_o;
    logic            taken_o;
    target_sel_t     tgt_o;
    logic [11:0]     ea;
    logic [11:0]     eb;
    logic [11:0]     es;
    logic [3:0]      eset;
    logic [31:0]     lfsr;
    int              fail_count;
    int              total_checks;

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    host_link_model host_u (.sclk_o(sclk), .cs_n_o(cs_n), .sdata_o(sdata));

    dual_dac_serial_word_decoder dut_u (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk),
        .cs_n_i(cs_n), .sdata_i(sdata), .channel_a_code_o(a_o),
        .channel_b_code_o(b_o), .staging_code_o(s_o), .setting_o(set_o),
        .reference_external_o(ext_o), .reference_high_o(high_o),
        .last_target_o(tgt_o), .last_partial_o(part_o),
        .word_taken_o(taken_o));

    function automatic logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : next_rand

    function automatic void predict(input logic [15:0] w);
        command_word_t c = w;
        eset[3] = c.speed_select_bit;
        eset[2] = c.power_down_bit;
        case ({c.target_select_high, c.target_select_low})
            2'h0:
            begin
                eb = c.payload;
                es = c.payload;
            end
            2'h1: es = c.payload;
            2'h2:
            begin
                eb = es;
                ea = c.payload;
            end
            default: eset[1:0] = c.payload[1:0];
        endcase
    endfunction : predict

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic check_all(input logic [1:0] tgt, input logic part);
        check_val({4'h0, a_o}, {4'h0, ea});
        check_val({4'h0, b_o}, {4'h0, eb});
        check_val({4'h0, s_o}, {4'h0, es});
        check_val({12'h0, set_o}, {12'h0, eset});
        check_val({14'h0, ext_o, high_o}, {14'h0, eset[1] ~^ eset[0],
            eset[1] & ~eset[0]});
        check_val({13'h0, tgt_o, part_o}, {13'h0, tgt, part});
    endtask : check_all

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic wait_taken();
        int n;
        n = 0;
        while (taken_o !== 1'b1 && n < 40)
        begin
            @(posedge clk_i);
            #2;
            n++;
        end
        if (taken_o !== 1'b1)
        begin
            fail_count++;
            stop_test();
        end
    endtask : wait_taken

    // short frames keep only the bits sent, zero-filled above
    task automatic run(input logic [31:0] bits, input int n);
        logic [15:0] w;
        w = (n < 16) ? bits[15:0] & ~(16'hFFFF << n) : bits[15:0];
        if (n == 32)
            predict(bits[31:16]);
        predict(w);
        host_u.send(bits, n);
        wait_taken();
        check_all({w[15], w[12]}, n < 16);
    endtask : run

    task automatic reset_pulse();
        reset_n_i = 1'b0;
        {ea, eb, es, eset} = '0;
        repeat (2) @(posedge clk_i);
        #2;
        check_all(2'h0, 1'b0);
        reset_n_i = 1'b1;
        repeat (3) @(posedge clk_i);
        #2;
    endtask : reset_pulse

    initial
    begin
        fail_count   = 0;
        total_checks = 0;
        lfsr         = 32'hE8C8;
        reset_n_i    = 1'b0;
        repeat (14) @(posedge clk_i);
        #2;
        reset_pulse();
        // every reference code, then a channel word to show it sticks
        for (int i = 0; i < 4; i++)
        begin
            run({16'h0, 4'h9, 10'h0, i[1:0]}, 16);
            run({16'h0, 16'hC5A5}, 16);
        end
        for (int i = 0; i < 40; i++)
        begin
            lfsr = next_rand(lfsr);
            run({16'h0, lfsr[15:0]}, 16);
        end
        run({16'h1ABC, 16'h8123}, 32);
        run(32'hFFFF, 10);
        host_u.send(32'h0, 0);
        repeat (10) @(posedge clk_i);
        #2;
        check_all(2'h0, 1'b1);
        reset_pulse();
        run({16'h0, 16'h6F0E}, 16);
        stop_test();
    end
endmodule : dual_dac_serial_word_decoder_tb
